/* File: inc/rnpc_pkg.sv */
package rnpc_pkg;
  // ==========================================================
  // timing, widths and boot bit
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILT_REJECT_NS = 10;
  localparam int FILT_PASS_NS = 100;
  // shortest low that must be seen before it counts; longest pass rounds down
  localparam int FILT_CYC_RAW = FILT_PASS_NS / CLK_PERIOD_NS;
  localparam int FILT_CYCLES = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
  localparam int SYNC_STAGES = 2;
  localparam int INT_RESET_CYCLES = 64;
  localparam int CFG_WIDTH = 8;
  localparam int BOOT_BIT = 4;
  // reset source flag encoding
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_HW_SHORT = 3'h1;
  localparam logic [2:0] SRC_HW_LONG = 3'h2;
  localparam logic [2:0] SRC_SW = 3'h3;
  localparam logic [2:0] SRC_WDT = 3'h4;
  typedef enum logic [1:0] {RNPC_RUN, RNPC_SEQ, RNPC_INIT} rnpc_state_e;
endpackage

/* File: core/rnpc_ctrl.sv */
// Contract
// [RQ1] low reset pin with clock resets device
// [RQ2] filter drops short lows, passes long ones
// [RQ3] source holds pin low 100ns plus two
// [RQ4] bidir mode drives pin low during sequence
// [RQ5] indication low during any reset kind
// [RQ6] indication stays low until end-of-init
// [RQ7] nmi falling edge raises trap request
// [RQ8] power-down only when nmi is low
// [RQ9] bidir enable locked after init, reset-cleared
// [RQ10] bidir mode reports long hardware reset
// [RQ11] bidir mode latches port config, boot select
// [RQ12] bidir mode stretches short hardware reset
// [RQ13] pin inputs synchronised before use
`default_nettype none
module rnpc_ctrl
  import rnpc_pkg::*;
#(
  parameter int SEQ_CYCLES = INT_RESET_CYCLES,
  parameter int FILT_LEN = FILT_CYCLES
)(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_reset_request_pin_n,
  input wire logic i_nmi_n,
  input wire logic i_sw_reset,
  input wire logic i_wdt_reset,
  input wire logic i_end_of_init_instruction,
  input wire logic i_power_down_instruction,
  input wire logic i_bidir_reset_enable_wr,
  input wire logic i_bidir_reset_enable_wdata,
  input wire logic [CFG_WIDTH-1:0] i_low_data_port_config,
  output logic o_reset_request_pin_n,
  output logic o_reset_request_pin_oe_n,
  output logic o_reset_indication_out_n,
  output logic o_core_reset,
  output logic o_nmi_trap,
  output logic o_power_down,
  output logic o_bidir_reset_enable,
  output logic [2:0] o_reset_source,
  output logic [CFG_WIDTH-1:0] o_config_latched,
  output logic o_boot_select
);

  // ==========================================================
  // synchronisers
  logic [SYNC_STAGES-1:0] rst_sync_q, rst_sync_d;
  logic [SYNC_STAGES-1:0] nmi_sync_q, nmi_sync_d;
  logic nmi_prev_q, nmi_prev_d;

  // first stage feeds only the second
  always_comb
  begin
    rst_sync_d = {rst_sync_q[SYNC_STAGES-2:0], i_reset_request_pin_n}; // see [RQ13]
    nmi_sync_d = {nmi_sync_q[SYNC_STAGES-2:0], i_nmi_n}; // see [RQ13]
    nmi_prev_d = nmi_sync_q[SYNC_STAGES-1];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      rst_sync_q <= '1;
      nmi_sync_q <= '1;
      nmi_prev_q <= 1'b1;
    end
    else
    begin
      rst_sync_q <= rst_sync_d;
      nmi_sync_q <= nmi_sync_d;
      nmi_prev_q <= nmi_prev_d;
    end
  end

  logic pin_low;
  logic nmi_level;
  assign pin_low = ~rst_sync_q[SYNC_STAGES-1];
  assign nmi_level = nmi_sync_q[SYNC_STAGES-1];

  // ==========================================================
  // spike filter: low must persist FILT_LEN cycles
  // sampling at 20 ns already drops sub-10 ns spikes mostly; the count makes it certain
  logic [7:0] filt_cnt_q, filt_cnt_d;
  logic filt_low;

  always_comb
  begin
    filt_cnt_d = filt_cnt_q;
    if (!pin_low)
      filt_cnt_d = '0; // see [RQ2]
    else if (filt_cnt_q < 8'(FILT_LEN))
      filt_cnt_d = filt_cnt_q + 8'h01;
  end

  assign filt_low = (filt_cnt_q == 8'(FILT_LEN)); // see [RQ2]

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      filt_cnt_q <= '0;
    else
      filt_cnt_q <= filt_cnt_d;
  end

  // ==========================================================
  // reset sequencer
  rnpc_state_e state_q, state_d;
  logic [15:0] seq_cnt_q, seq_cnt_d;
  logic bdr_q, bdr_d;
  logic [2:0] src_q, src_d;
  logic [CFG_WIDTH-1:0] cfg_q, cfg_d;
  logic trap_q, trap_d;
  logic pd_q, pd_d;
  logic any_reset;
  logic hw_start;
  logic echo_q, echo_d;

  // own drive echo: after release the pin still reads low through the synchroniser,
  // and the filter would take that tail for a fresh external reset
  // limitation: an external low that overlaps the tail is never seen, since echo holds for as long as the pin reads low
  always_comb
  begin
    echo_d = (bdr_q && state_q == RNPC_SEQ) || (echo_q && pin_low); // see [RQ4]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      echo_q <= 1'b0;
    else
      echo_q <= echo_d;
  end

  // own pin drive is excluded so bidir mode does not hold itself in reset
  assign hw_start = filt_low && !echo_q && !(bdr_q && state_q == RNPC_SEQ);
  assign any_reset = hw_start || i_sw_reset || i_wdt_reset;

  function automatic logic [2:0] rnpc_src(input logic bidir, input logic hw, input logic sw, input logic long_hw);
    if (bidir)
      rnpc_src = SRC_HW_LONG; // see [RQ10]
    else if (hw)
      rnpc_src = long_hw ? SRC_HW_LONG : SRC_HW_SHORT;
    else if (sw)
      rnpc_src = SRC_SW;
    else
      rnpc_src = SRC_WDT;
  endfunction

  always_comb
  begin
    state_d = state_q;
    seq_cnt_d = seq_cnt_q;
    bdr_d = bdr_q;
    src_d = src_q;
    cfg_d = cfg_q;
    trap_d = 1'b0;
    pd_d = pd_q;
    unique case (state_q)
      RNPC_RUN, RNPC_INIT:
      begin
        if (any_reset)
        begin
          state_d = RNPC_SEQ; // see [RQ1]
          seq_cnt_d = '0;
          src_d = rnpc_src(bdr_q, hw_start, i_sw_reset, 1'b0);
          pd_d = 1'b0;
          if (hw_start || bdr_q)
            cfg_d = i_low_data_port_config; // see [RQ11]
        end
        else
        begin
          if (state_q == RNPC_INIT && i_end_of_init_instruction)
            state_d = RNPC_RUN; // see [RQ6]
          if (state_q == RNPC_INIT && i_bidir_reset_enable_wr)
            bdr_d = i_bidir_reset_enable_wdata; // see [RQ9]
          if (nmi_prev_q && !nmi_level)
            trap_d = 1'b1; // see [RQ7]
          if (i_power_down_instruction && !nmi_level)
            pd_d = 1'b1; // see [RQ8]
        end
      end
      RNPC_SEQ:
      begin
        // outside bidir mode, pin held low externally keeps the core in reset
        if (seq_cnt_q < 16'(SEQ_CYCLES))
          seq_cnt_d = seq_cnt_q + 16'h0001;
        else if (!filt_low || bdr_q)
        begin
          state_d = RNPC_INIT; // see [RQ12]
          bdr_d = 1'b0; // see [RQ9]
        end
        if (filt_low && !bdr_q && seq_cnt_q >= 16'(SEQ_CYCLES))
          src_d = SRC_HW_LONG;
      end
      default:
        state_d = RNPC_RUN;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      state_q <= RNPC_SEQ;
      seq_cnt_q <= '0;
      bdr_q <= 1'b0;
      src_q <= SRC_NONE;
      cfg_q <= '0;
      trap_q <= 1'b0;
      pd_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      seq_cnt_q <= seq_cnt_d;
      bdr_q <= bdr_d;
      src_q <= src_d;
      cfg_q <= cfg_d;
      trap_q <= trap_d;
      pd_q <= pd_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_reset_request_pin_n = 1'b0;
  assign o_reset_request_pin_oe_n = !(bdr_q && state_q == RNPC_SEQ); // see [RQ4]
  assign o_reset_indication_out_n = (state_q == RNPC_RUN); // see [RQ5]
  assign o_core_reset = (state_q == RNPC_SEQ);
  assign o_nmi_trap = trap_q;
  assign o_power_down = pd_q;
  assign o_bidir_reset_enable = bdr_q;
  assign o_reset_source = src_q;
  assign o_config_latched = cfg_q;
  assign o_boot_select = ~cfg_q[BOOT_BIT]; // see [RQ11]

  // ==========================================================
  // assertions
  ind_low_seq_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_q == RNPC_SEQ) |-> !o_reset_indication_out_n) else $error("indication high in reset"); // see [RQ5]
  ind_release_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_reset_indication_out_n) |-> $past(i_end_of_init_instruction)) else $error("release without init"); // see [RQ6]
  nmi_trap_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_q == RNPC_RUN && !any_reset && nmi_prev_q && !nmi_level) |=> o_nmi_trap) else $error("trap missed"); // see [RQ7]
  pd_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_power_down) |-> $past(!nmi_level && i_power_down_instruction)) else $error("power down with nmi high"); // see [RQ8]
  bdr_lock_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_q == RNPC_RUN) |=> $stable(o_bidir_reset_enable)) else $error("bidir changed after init"); // see [RQ9]
  bdr_drive_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (bdr_q && state_q == RNPC_SEQ) |-> !o_reset_request_pin_oe_n) else $error("pin not driven"); // see [RQ4]
  bdr_src_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (bdr_q && state_q != RNPC_SEQ && any_reset) |=> (o_reset_source == SRC_HW_LONG)) else $error("bad source"); // see [RQ10]
  filt_reset_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!pin_low) |=> (filt_cnt_q == 8'h00)) else $error("filter not cleared"); // see [RQ2]
  seq_len_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_q == RNPC_SEQ && seq_cnt_q < 16'(SEQ_CYCLES)) |=> (state_q == RNPC_SEQ)) else $error("short sequence"); // see [RQ12]

  // bidir sequence ends once the count is done, own drive or not
  seq_exit_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ12]
    (bdr_q && state_q == RNPC_SEQ && seq_cnt_q >= 16'(SEQ_CYCLES)) |=> (state_q == RNPC_INIT)) else $error("bidir sequence stuck");

  // the pin tail after own drive must not restart the sequence
  no_retrig_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ4]
    $rose(o_reset_request_pin_oe_n) |-> !hw_start [*4]) else $error("own drive retriggered");

  // pin only driven while bidir mode is on
  oe_idle_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ4]
    !o_bidir_reset_enable |-> o_reset_request_pin_oe_n) else $error("pin driven without bidir");

  // bidir enable is gone as soon as the sequence ends
  bdr_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ9]
    $fell(o_core_reset) |-> !o_bidir_reset_enable) else $error("bidir kept after reset");

  // indication is low whenever core reset is high
  core_ind_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ5]
    o_core_reset |-> !o_reset_indication_out_n) else $error("indication high in core reset");

  // watchdog cause reported when nothing else asks
  src_wdt_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ5]
    (state_q != RNPC_SEQ && !bdr_q && !hw_start && !i_sw_reset && i_wdt_reset) |=> (o_reset_source == SRC_WDT))
    else $error("watchdog source wrong");

  // trap is a single-cycle request
  trap_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ7]
    o_nmi_trap |=> !o_nmi_trap) else $error("trap longer than one cycle");

  // trap only follows a synchronised low level
  trap_sync_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ13]
    o_nmi_trap |-> $past(!nmi_level)) else $error("trap without synced low");

  // power-down never survives into a reset sequence
  pd_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ8]
    o_core_reset |-> !o_power_down) else $error("power down in reset");

  // filter count saturates at its length
  filt_cap_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ2]
    filt_cnt_q <= 8'(FILT_LEN)) else $error("filter count overrun");

  // latched configuration frozen during the sequence
  cfg_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst) // see [RQ11]
    (state_q == RNPC_SEQ) |=> $stable(o_config_latched)) else $error("config changed in sequence");

endmodule
`default_nettype wire

/* File: sim/rnpc_partner.sv */
`default_nettype none
// ==========================================================
// reset source and nmi source outside the device
module rnpc_partner (
  input wire logic i_core_clk,
  output logic o_pull_low,
  output logic o_nmi_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // open drain only: released pin floats up through the pull-up
  initial
  begin
    o_pull_low = 1'b0;
    o_nmi_n = 1'b1;
  end
  // pull the pin low for n cycles, called just after an edge
  task automatic hold_low(input int n);
    o_pull_low <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    o_pull_low <= 1'b0;
  endtask
  task automatic set_nmi(input logic v);
    o_nmi_n <= v;
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`default_nettype none
// ==========================================================
// bench for the reset, nmi and power-down block
module tb_top
  import rnpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, sw, wdt, eoi, pd, bwr, bwd;
  logic [7:0] cfg, cfg_q;
  logic pull_low, nmi_n, pin_o, oe_n, ind_n, core, trap, pdn, ben, boot;
  logic [2:0] src;
  wire pin_n;
  int err_total, checks_done;
  // wired-and of both drivers, high otherwise
  assign pin_n = (pull_low || (oe_n === 1'b0 && pin_o === 1'b0)) ? 1'b0 : 1'b1;
  rnpc_partner i_partner (.i_core_clk(clk), .o_pull_low(pull_low), .o_nmi_n(nmi_n));
  rnpc_ctrl #(.SEQ_CYCLES(4), .FILT_LEN(5)) i_dut (.i_core_clk(clk), .i_rst(rst),
    .i_reset_request_pin_n(pin_n), .i_nmi_n(nmi_n), .i_sw_reset(sw), .i_wdt_reset(wdt),
    .i_end_of_init_instruction(eoi), .i_power_down_instruction(pd),
    .i_bidir_reset_enable_wr(bwr), .i_bidir_reset_enable_wdata(bwd),
    .i_low_data_port_config(cfg), .o_reset_request_pin_n(pin_o),
    .o_reset_request_pin_oe_n(oe_n), .o_reset_indication_out_n(ind_n),
    .o_core_reset(core), .o_nmi_trap(trap), .o_power_down(pdn),
    .o_bidir_reset_enable(ben), .o_reset_source(src),
    .o_config_latched(cfg_q), .o_boot_select(boot));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // bounded wait on the core reset level; a hang ends the run
  task automatic wait_core(input logic v);
    int n;
    n = 0;
    while (core !== v && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (core !== v)
    begin
      chk(1'b0, "core reset wait ran out");
      end_sim();
    end
  endtask
  localparam int P_EOI = 0;
  localparam int P_PD = 1;
  localparam int P_BWR = 2;
  localparam int P_SW = 3;
  localparam int P_WDT = 4;
  // one strobe picked by number; a ref argument cannot take a non-blocking write
  task automatic drive(input int which, input logic v);
    case (which)
      P_EOI: eoi <= v;
      P_PD: pd <= v;
      P_BWR: bwr <= v;
      P_SW: sw <= v;
      default: wdt <= v;
    endcase
  endtask
  task automatic pulse(input int which);
    @(posedge clk);
    drive(which, 1'b1);
    @(posedge clk);
    drive(which, 1'b0);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_pin();
    @(posedge clk);
    i_partner.hold_low(2);
    repeat (12) @(posedge clk);
    #1;
    chk(core === 1'b0, "short low pulse passed");
    i_partner.hold_low(8);
    wait_core(1'b1);
    chk(ind_n === 1'b0, "indication high in reset");
    wait_core(1'b0);
    chk(ind_n === 1'b0, "indication left before init end");
    chk(src === SRC_HW_SHORT, "source not short hardware");
    $display("pin reset test done");
  endtask
  task automatic t_init();
    pulse(P_EOI);
    chk(ind_n === 1'b1, "indication held after init end");
    bwd <= 1'b1;
    pulse(P_BWR);
    chk(ben === 1'b0, "bidir enable written after init");
    $display("init end test done");
  endtask
  task automatic t_nmi();
    int n;
    i_partner.set_nmi(1'b0);
    n = 0;
    while (trap !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(trap === 1'b1, "no trap on nmi fall");
    pulse(P_PD);
    chk(pdn === 1'b1, "no power-down with nmi low");
    $display("nmi test done");
  endtask
  task automatic t_bidir();
    i_partner.set_nmi(1'b1);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_core(1'b0);
    chk(pdn === 1'b0, "power-down kept over reset");
    pulse(P_PD);
    chk(pdn === 1'b0, "power-down with nmi high");
    cfg <= 8'h05;
    bwd <= 1'b1;
    pulse(P_BWR);
    chk(ben === 1'b1, "bidir enable not taken in init");
    sw <= 1'b1;
    @(posedge clk);
    sw <= 1'b0;
    wait_core(1'b1);
    chk(oe_n === 1'b0 && pin_n === 1'b0, "pin not pulled in sequence");
    chk(src === SRC_HW_LONG, "source not long hardware");
    chk(cfg_q === 8'h05 && boot === 1'b1, "config or boot wrong");
    wait_core(1'b0);
    chk(ben === 1'b0 && oe_n === 1'b1, "bidir enable survived reset");
    repeat (6) @(posedge clk);
    #1;
    chk(core === 1'b0 && src === SRC_HW_LONG, "own pin drive retriggered");
    $display("bidir test done");
  endtask
  // watchdog reset outside bidir mode leaves the config alone; the software reset is checked for core reset and its source, not the config
  task automatic t_wdt();
    cfg <= 8'haa;
    pulse(P_WDT);
    chk(core === 1'b1 && ind_n === 1'b0, "no reset on watchdog");
    chk(src === SRC_WDT && cfg_q === 8'h05, "watchdog source or config wrong");
    wait_core(1'b0);
    pulse(P_SW);
    chk(core === 1'b1 && src === SRC_SW, "software reset source wrong");
    wait_core(1'b0);
    chk(ind_n === 1'b0, "indication high before init end");
    $display("watchdog test done");
  endtask
  initial
  begin
    {sw, wdt, eoi, pd, bwr, bwd} = 6'h00;
    cfg = 8'hff;
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_core(1'b0);
    t_pin();
    t_init();
    t_nmi();
    t_bidir();
    t_wdt();
    end_sim();
  end
endmodule
`default_nettype wire
